/* rtl/omr_routing_regs.v */
/*
 * output mixer routing register bank: speaker boost routing,
 * earpiece mixer and mute, first line output pair mode, paths,
 * mutes and attenuation, reached over avalon-mm.
 * assumes byte addressing, 32-bit data, registers in the low half.
 * all route and mute outputs are registered path enables for the
 * analogue section; they follow a write by one clock.
 */
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "omr_defines.vh"
module omr_routing_regs #(
  parameter NREG = 6
) (
  input  wire        clk_sys_i,
  input  wire        srst_i,
  input  wire        ce_i,
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  output reg         left_mix_to_left_driver_o,
  output reg         right_mix_to_left_driver_o,
  output reg         left_mix_to_right_driver_o,
  output reg         right_mix_to_right_driver_o,
  output reg         left_outmix_to_earpiece_o,
  output reg         right_outmix_to_earpiece_o,
  output reg         earpiece_mute_o,
  output reg         earpiece_atten_o,
  output reg         line_pair_a_mode_o,
  output reg         left_outmix_to_line_a_neg_o,
  output reg         right_outmix_to_line_a_neg_o,
  output reg         right_inamp_to_line_a_diff_o,
  output reg         left_inamp_to_line_a_diff_o,
  output reg         left_outmix_to_line_a_diff_o,
  output reg         left_outmix_to_line_a_pos_o,
  output reg         line_a_neg_mute_o,
  output reg         line_a_pos_mute_o,
  output reg         line_a_atten_o,
  output reg         line_midrail_buffer_enable_o
);

  // register table lookups, used at elaboration
  function [5:0] reg_idx;
    input integer i;
    begin
      case (i)
        0:       reg_idx = `OMR_IDX_LINE_VOL;
        1:       reg_idx = `OMR_IDX_EAR_VOL;
        2:       reg_idx = `OMR_IDX_SPK_ROUTE;
        3:       reg_idx = `OMR_IDX_EAR_MIX;
        4:       reg_idx = `OMR_IDX_LINE_MIX;
        default: reg_idx = `OMR_IDX_CTRL;
      endcase
    end
  endfunction

  function [15:0] reg_mask;
    input integer i;
    begin
      case (i)
        0:       reg_mask = `OMR_MASK_LINE_VOL;
        1:       reg_mask = `OMR_MASK_EAR_VOL;
        2:       reg_mask = `OMR_MASK_SPK_ROUTE;
        3:       reg_mask = `OMR_MASK_EAR_MIX;
        4:       reg_mask = `OMR_MASK_LINE_MIX;
        default: reg_mask = `OMR_MASK_CTRL;
      endcase
    end
  endfunction

  function [15:0] reg_rst;
    input integer i;
    begin
      case (i)
        0:       reg_rst = `OMR_RST_LINE_VOL;
        1:       reg_rst = `OMR_RST_EAR_VOL;
        2:       reg_rst = `OMR_RST_SPK_ROUTE;
        3:       reg_rst = `OMR_RST_EAR_MIX;
        4:       reg_rst = `OMR_RST_LINE_MIX;
        default: reg_rst = `OMR_RST_CTRL;
      endcase
    end
  endfunction

  wire [5:0]      acc_idx;
  wire            rd_load;
  wire            wr_commit;
  wire [16*6-1:0] reg_flat;
  wire [15:0]     line_vol;
  wire [15:0]     ear_vol;
  wire [15:0]     spk_route;
  wire [15:0]     ear_mix;
  wire [15:0]     line_mix;
  wire [15:0]     ctrl;
  reg  [15:0]     status;
  reg  [15:0]     next_rdata;

  // low address bits ignored: every register is word aligned
  assign acc_idx = avs_address_i[7:2];

  omr_bus_slave u_bus (
    .clk_sys_i     (clk_sys_i),
    .srst_i        (srst_i),
    .ce_i          (ce_i),
    .read_i        (avs_read_i),
    .write_i       (avs_write_i),
    .waitrequest_o (avs_waitrequest_o),
    .rd_load_o     (rd_load),
    .wr_commit_o   (wr_commit)
  );

  // one storage register per table entry
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_reg
      omr_field_reg #(
        .MASK (reg_mask(g)),
        .RST  (reg_rst(g))
      ) u_field (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .wr_i      (wr_commit && (acc_idx == reg_idx(g))),
        .be_i      (avs_byteenable_i[1:0]),
        .wdata_i   (avs_writedata_i[15:0]),
        .q_o       (reg_flat[16*g +: 16])
      );
    end
  endgenerate

  // named views of the stored registers
  assign line_vol  = reg_flat[15:0];
  assign ear_vol   = reg_flat[31:16];
  assign spk_route = reg_flat[47:32];
  assign ear_mix   = reg_flat[63:48];
  assign line_mix  = reg_flat[79:64];
  assign ctrl      = reg_flat[95:80];

  // live warnings on software's side of the bargain
  always @* begin
    status = 16'h0000;
    status[`OMR_BIT_ST_SE_NOBUF] = line_mix[`OMR_BIT_LA_MODE]
                                   & ~ctrl[`OMR_BIT_MIDRAIL_BUF];
    status[`OMR_BIT_ST_EAR_CLIP] = ear_mix[`OMR_BIT_LOM_TO_EAR]
                                   & ear_mix[`OMR_BIT_ROM_TO_EAR]
                                   & ~ear_vol[`OMR_BIT_EAR_ATTEN];
    status[`OMR_BIT_ST_LA_CLIP]  = ~line_vol[`OMR_BIT_LA_ATTEN]
                                   & (line_mix[`OMR_BIT_LA_MODE]
                                   ? line_mix[`OMR_BIT_LOM_TO_NEG]
                                     & line_mix[`OMR_BIT_ROM_TO_NEG]
                                   : (line_mix[`OMR_BIT_RIA_TO_DIFF]
                                     + line_mix[`OMR_BIT_LIA_TO_DIFF]
                                     + line_mix[`OMR_BIT_LOM_TO_POS]) > 2'd1);
  end

  // read mux; unmapped addresses answer zero
  always @* begin
    case (acc_idx)
      `OMR_IDX_LINE_VOL:  next_rdata = line_vol;
      `OMR_IDX_EAR_VOL:   next_rdata = ear_vol;
      `OMR_IDX_SPK_ROUTE: next_rdata = spk_route;
      `OMR_IDX_EAR_MIX:   next_rdata = ear_mix;
      `OMR_IDX_LINE_MIX:  next_rdata = line_mix;
      `OMR_IDX_CTRL:      next_rdata = ctrl;
      `OMR_IDX_STATUS:    next_rdata = status;
      default:            next_rdata = 16'h0000;
    endcase
  end

  // read data held until the next read is taken
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_load) begin
      avs_readdata_o <= {16'h0000, next_rdata};
    end
  end

  // speaker boost routing, any mixer to either driver
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      left_mix_to_left_driver_o   <= 1'b1;
      right_mix_to_left_driver_o  <= 1'b0;
      left_mix_to_right_driver_o  <= 1'b0;
      right_mix_to_right_driver_o <= 1'b1;
    end else if (ce_i) begin
      left_mix_to_left_driver_o   <= spk_route[`OMR_BIT_L_TO_LDRV];
      right_mix_to_left_driver_o  <= spk_route[`OMR_BIT_R_TO_LDRV];
      left_mix_to_right_driver_o  <= spk_route[`OMR_BIT_L_TO_RDRV];
      right_mix_to_right_driver_o <= spk_route[`OMR_BIT_R_TO_RDRV];
    end
  end

  // earpiece driver mixer and output stage
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      left_outmix_to_earpiece_o  <= 1'b0;
      right_outmix_to_earpiece_o <= 1'b0;
      earpiece_mute_o            <= 1'b1;
      earpiece_atten_o           <= 1'b0;
    end else if (ce_i) begin
      left_outmix_to_earpiece_o  <= ear_mix[`OMR_BIT_LOM_TO_EAR];
      right_outmix_to_earpiece_o <= ear_mix[`OMR_BIT_ROM_TO_EAR];
      earpiece_mute_o            <= ear_vol[`OMR_BIT_EAR_MUTE];
      earpiece_atten_o           <= ear_vol[`OMR_BIT_EAR_ATTEN];
    end
  end

  // first line pair: paths only live in the mode that owns them,
  // so a stale enable from the other mode cannot reach the pins
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      line_pair_a_mode_o           <= 1'b0;
      left_outmix_to_line_a_neg_o  <= 1'b0;
      right_outmix_to_line_a_neg_o <= 1'b0;
      right_inamp_to_line_a_diff_o <= 1'b0;
      left_inamp_to_line_a_diff_o  <= 1'b0;
      left_outmix_to_line_a_diff_o <= 1'b0;
      left_outmix_to_line_a_pos_o  <= 1'b0;
    end else if (ce_i) begin
      line_pair_a_mode_o           <= line_mix[`OMR_BIT_LA_MODE];
      left_outmix_to_line_a_neg_o  <= line_mix[`OMR_BIT_LA_MODE]
                                      & line_mix[`OMR_BIT_LOM_TO_NEG];
      right_outmix_to_line_a_neg_o <= line_mix[`OMR_BIT_LA_MODE]
                                      & line_mix[`OMR_BIT_ROM_TO_NEG];
      right_inamp_to_line_a_diff_o <= ~line_mix[`OMR_BIT_LA_MODE]
                                      & line_mix[`OMR_BIT_RIA_TO_DIFF];
      left_inamp_to_line_a_diff_o  <= ~line_mix[`OMR_BIT_LA_MODE]
                                      & line_mix[`OMR_BIT_LIA_TO_DIFF];
      left_outmix_to_line_a_diff_o <= ~line_mix[`OMR_BIT_LA_MODE]
                                      & line_mix[`OMR_BIT_LOM_TO_POS];
      left_outmix_to_line_a_pos_o  <= line_mix[`OMR_BIT_LA_MODE]
                                      & line_mix[`OMR_BIT_LOM_TO_POS];
    end
  end

  // line pair output stage; mutes act in either mode
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      line_a_neg_mute_o            <= 1'b1;
      line_a_pos_mute_o            <= 1'b1;
      line_a_atten_o               <= 1'b0;
      line_midrail_buffer_enable_o <= 1'b0;
    end else if (ce_i) begin
      line_a_neg_mute_o            <= line_vol[`OMR_BIT_LA_NEG_MUTE];
      line_a_pos_mute_o            <= line_vol[`OMR_BIT_LA_POS_MUTE];
      line_a_atten_o               <= line_vol[`OMR_BIT_LA_ATTEN];
      // software owns this; not forced, only flagged in status
      line_midrail_buffer_enable_o <= ctrl[`OMR_BIT_MIDRAIL_BUF];
    end
  end

endmodule

/* rtl/omr_defines.vh */
/*
 * constants for the output mixer routing register bank: register
 * indices, field positions, write masks and reset values.
 * assumes byte address = 4 * index on a 32-bit avalon-mm slave.
 */
`ifndef OMR_DEFINES_VH
`define OMR_DEFINES_VH

// register indices (byte address is four times these)
`define OMR_IDX_LINE_VOL   6'h1E
`define OMR_IDX_EAR_VOL    6'h1F
`define OMR_IDX_SPK_ROUTE  6'h24
`define OMR_IDX_EAR_MIX    6'h33
`define OMR_IDX_LINE_MIX   6'h34
`define OMR_IDX_CTRL       6'h38
`define OMR_IDX_STATUS     6'h39

// line output volume fields
`define OMR_BIT_LA_NEG_MUTE 6
`define OMR_BIT_LA_POS_MUTE 5
`define OMR_BIT_LA_ATTEN    4
`define OMR_MASK_LINE_VOL   16'h0070
`define OMR_RST_LINE_VOL    16'h0060

// earpiece volume fields
`define OMR_BIT_EAR_MUTE    5
`define OMR_BIT_EAR_ATTEN   4
`define OMR_MASK_EAR_VOL    16'h0030
`define OMR_RST_EAR_VOL     16'h0020

// speaker boost routing fields
`define OMR_BIT_L_TO_LDRV   4
`define OMR_BIT_R_TO_LDRV   3
`define OMR_BIT_L_TO_RDRV   1
`define OMR_BIT_R_TO_RDRV   0
`define OMR_MASK_SPK_ROUTE  16'h001B
`define OMR_RST_SPK_ROUTE   16'h0011

// earpiece mixer select fields
`define OMR_BIT_LOM_TO_EAR  4
`define OMR_BIT_ROM_TO_EAR  3
`define OMR_MASK_EAR_MIX    16'h0018
`define OMR_RST_EAR_MIX     16'h0000

// first line mixer fields
`define OMR_BIT_LOM_TO_NEG  6
`define OMR_BIT_ROM_TO_NEG  5
`define OMR_BIT_LA_MODE     4
`define OMR_BIT_RIA_TO_DIFF 2
`define OMR_BIT_LIA_TO_DIFF 1
`define OMR_BIT_LOM_TO_POS  0
`define OMR_MASK_LINE_MIX   16'h0077
`define OMR_RST_LINE_MIX    16'h0000

// control: mid-rail buffer enable
`define OMR_BIT_MIDRAIL_BUF 0
`define OMR_MASK_CTRL       16'h0001
`define OMR_RST_CTRL        16'h0000

// status bits
`define OMR_BIT_ST_SE_NOBUF 0
`define OMR_BIT_ST_EAR_CLIP 1
`define OMR_BIT_ST_LA_CLIP  2

`endif

/* rtl/omr_field_reg.v */
/*
 * one software register: masked 16-bit storage with byte lanes.
 * assumes a one-cycle write strobe from the bus handshake.
 */
`timescale 1ns/1ps
module omr_field_reg #(
  parameter [15:0] MASK = 16'hFFFF,
  parameter [15:0] RST  = 16'h0000
) (
  input  wire        clk_sys_i,
  input  wire        srst_i,
  input  wire        ce_i,
  input  wire        wr_i,
  input  wire [1:0]  be_i,
  input  wire [15:0] wdata_i,
  output reg  [15:0] q_o
);

  // unimplemented bits stay zero whatever is written
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      q_o <= RST & MASK;
    end else if (ce_i && wr_i) begin
      if (be_i[0]) begin
        q_o[7:0] <= wdata_i[7:0] & MASK[7:0];
      end
      if (be_i[1]) begin
        q_o[15:8] <= wdata_i[15:8] & MASK[15:8];
      end
    end
  end

endmodule

/* rtl/omr_bus_slave.v */
/*
 * avalon-mm handshake: one wait state on every access.
 * assumes the master holds read or write until waitrequest is low.
 */
`timescale 1ns/1ps
module omr_bus_slave (
  input  wire clk_sys_i,
  input  wire srst_i,
  input  wire ce_i,
  input  wire read_i,
  input  wire write_i,
  output reg  waitrequest_o,
  output wire rd_load_o,
  output wire wr_commit_o
);

  // read data captured while the wait state is shown
  assign rd_load_o   = ce_i && read_i && waitrequest_o;
  // write lands on the edge where waitrequest is seen low
  assign wr_commit_o = ce_i && write_i && !waitrequest_o;

  // high when idle so a new request always gets one wait cycle
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      if ((read_i || write_i) && waitrequest_o) begin
        waitrequest_o <= 1'b0;
      end else begin
        waitrequest_o <= 1'b1;
      end
    end
  end

endmodule

/* verification/omr_checker.sv */
/* checker: bus handshake and field-to-pin relations of the routing bank.
   assumes the ports of omr_routing_regs, attached by the bind below. */
`timescale 1ns/1ps
module omr_checker (
  input logic        clk_sys_i,
  input logic        srst_i,
  input logic        ce_i,
  input logic [7:0]  avs_address_i,
  input logic        avs_read_i,
  input logic        avs_write_i,
  input logic [31:0] avs_writedata_i,
  input logic [3:0]  avs_byteenable_i,
  input logic [31:0] avs_readdata_o,
  input logic        avs_waitrequest_o,
  input logic        left_mix_to_left_driver_o,
  input logic        right_mix_to_left_driver_o,
  input logic        left_mix_to_right_driver_o,
  input logic        right_mix_to_right_driver_o,
  input logic        left_outmix_to_earpiece_o,
  input logic        right_outmix_to_earpiece_o,
  input logic        earpiece_mute_o,
  input logic        earpiece_atten_o,
  input logic        line_pair_a_mode_o,
  input logic        left_outmix_to_line_a_neg_o,
  input logic        right_outmix_to_line_a_neg_o,
  input logic        right_inamp_to_line_a_diff_o,
  input logic        left_inamp_to_line_a_diff_o,
  input logic        left_outmix_to_line_a_diff_o,
  input logic        left_outmix_to_line_a_pos_o,
  input logic        line_a_neg_mute_o,
  input logic        line_a_pos_mute_o,
  input logic        line_a_atten_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // low byte committed at this edge; pins follow one edge on and are checked the edge after
  wire        wcom = avs_write_i && !avs_waitrequest_o && ce_i && avs_byteenable_i[0];
  wire [31:0] wd   = avs_writedata_i;
  wire        w78  = wcom && avs_address_i == 8'h78;
  wire        w7c  = wcom && avs_address_i == 8'h7c;
  wire        w90  = wcom && avs_address_i == 8'h90;
  wire        wcc  = wcom && avs_address_i == 8'hcc;
  wire        wd0  = wcom && avs_address_i == 8'hd0;

  AST_SPK_ROUTE: assert property (
    w90 ##1 ce_i |=> {left_mix_to_left_driver_o, right_mix_to_left_driver_o,
    left_mix_to_right_driver_o, right_mix_to_right_driver_o} == $past({wd[4], wd[3], wd[1], wd[0]}, 2))
    else $error("speaker routing pins differ from written bits");
  AST_EAR_MUTE: assert property (
    w7c ##1 ce_i |=> earpiece_mute_o == $past(wd[5], 2))
    else $error("earpiece mute pin differs from written bit");
  AST_EAR_ATTEN: assert property (
    w7c ##1 ce_i |=> earpiece_atten_o == $past(wd[4], 2))
    else $error("earpiece attenuation pin differs from written bit");
  AST_EAR_MIX: assert property (
    wcc ##1 ce_i |=> {left_outmix_to_earpiece_o, right_outmix_to_earpiece_o} == $past(wd[4:3], 2))
    else $error("earpiece source pins differ from written bits");
  AST_LINE_MODE: assert property (
    wd0 ##1 ce_i |=> line_pair_a_mode_o == $past(wd[4], 2))
    else $error("line pair mode pin differs from written bit");
  AST_SE_PATHS: assert property (
    wd0 ##1 ce_i |=> {left_outmix_to_line_a_neg_o, right_outmix_to_line_a_neg_o,
    left_outmix_to_line_a_pos_o} == ($past(wd[4], 2) ? $past({wd[6], wd[5], wd[0]}, 2) : 3'h0))
    else $error("single-ended paths wrong for written mode");
  AST_DIFF_PATHS: assert property (
    wd0 ##1 ce_i |=> {right_inamp_to_line_a_diff_o, left_inamp_to_line_a_diff_o,
    left_outmix_to_line_a_diff_o} == ($past(wd[4], 2) ? 3'h0 : $past(wd[2:0], 2)))
    else $error("differential paths wrong for written mode");
  AST_LINE_VOL: assert property (
    w78 ##1 ce_i |=> {line_a_neg_mute_o, line_a_pos_mute_o, line_a_atten_o} == $past(wd[6:4], 2))
    else $error("line mute or attenuation pins differ from written bits");
  AST_ONE_WAIT: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("access not answered after exactly one wait cycle");
  AST_RD_UPPER: assert property (
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
endmodule

bind omr_routing_regs omr_checker u_omr_checker (.clk_sys_i, .srst_i, .ce_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .left_mix_to_left_driver_o, .right_mix_to_left_driver_o,
  .left_mix_to_right_driver_o, .right_mix_to_right_driver_o, .left_outmix_to_earpiece_o,
  .right_outmix_to_earpiece_o, .earpiece_mute_o, .earpiece_atten_o, .line_pair_a_mode_o,
  .left_outmix_to_line_a_neg_o, .right_outmix_to_line_a_neg_o, .right_inamp_to_line_a_diff_o,
  .left_inamp_to_line_a_diff_o, .left_outmix_to_line_a_diff_o, .left_outmix_to_line_a_pos_o,
  .line_a_neg_mute_o, .line_a_pos_mute_o, .line_a_atten_o);

/* verification/omr_routing_regs_bench.sv */
/* bench: drives the routing bank over avalon-mm, keeps a register model
   and compares readback after every access, path pins after every write and reset.
   assumes one clock; ce_i held high except one three-cycle drop around a directed write. */
`timescale 1ns/1ps
module omr_routing_regs_bench;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [18:0] pins;
  logic [15:0] m [bit [7:0]];
  logic [7:0]  amap [8] = '{8'h78, 8'h7c, 8'h90, 8'hcc, 8'hd0, 8'he0, 8'he4, 8'h04};
  int          fails = 0;
  int          n_tests = 0;

  omr_routing_regs u_omr_routing_regs (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .left_mix_to_left_driver_o(pins[18]), .right_mix_to_left_driver_o(pins[17]),
    .left_mix_to_right_driver_o(pins[16]), .right_mix_to_right_driver_o(pins[15]),
    .left_outmix_to_earpiece_o(pins[14]), .right_outmix_to_earpiece_o(pins[13]),
    .earpiece_mute_o(pins[12]), .earpiece_atten_o(pins[11]), .line_pair_a_mode_o(pins[10]),
    .left_outmix_to_line_a_neg_o(pins[9]), .right_outmix_to_line_a_neg_o(pins[8]),
    .right_inamp_to_line_a_diff_o(pins[7]), .left_inamp_to_line_a_diff_o(pins[6]),
    .left_outmix_to_line_a_diff_o(pins[5]), .left_outmix_to_line_a_pos_o(pins[4]),
    .line_a_neg_mute_o(pins[3]), .line_a_pos_mute_o(pins[2]), .line_a_atten_o(pins[1]),
    .line_midrail_buffer_enable_o(pins[0]));

  // free-running system clock
  always #20 clk_sys_i = ~clk_sys_i;

  function automatic logic [15:0] msk(input logic [7:0] a);
    case (a)
      8'h78: msk = 16'h0070;
      8'h7c: msk = 16'h0030;
      8'h90: msk = 16'h001b;
      8'hcc: msk = 16'h0018;
      8'hd0: msk = 16'h0077;
      8'he0: msk = 16'h0001;
      default: msk = 16'h0000;
    endcase
  endfunction

  // status flags are advisory only: no path is forced off
  function automatic logic [15:0] stat();
    logic [15:0] l;
    l = m[8'hd0];
    stat = {13'h0000, !m[8'h78][4] && (l[4] ? l[6] && l[5] : ({1'b0, l[2]} + l[1] + l[0] >= 2'd2)),
      m[8'hcc][4] && m[8'hcc][3] && !m[8'h7c][4], l[4] && !m[8'he0][0]};
  endfunction

  // mode gates which line paths reach the pins
  function automatic logic [18:0] exp_pins();
    logic [15:0] s, x, e, v, l;
    s = m[8'h90]; x = m[8'hcc]; e = m[8'h7c]; v = m[8'h78]; l = m[8'hd0];
    exp_pins = {s[4], s[3], s[1], s[0], x[4], x[3], e[5], e[4], l[4], l[4] & l[6], l[4] & l[5],
      !l[4] & l[2], !l[4] & l[1], !l[4] & l[0], l[4] & l[0], v[6:4], m[8'he0][0]};
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH readdata at %h expected %h seen %h", a, e, g);
    end
  endtask

  task automatic chk_pins(input logic [18:0] e, input logic [18:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH path pins expected %b seen %b", e, g);
    end
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int k;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    if (wr) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (k >= 20) begin
      fails++;
      $display("MISMATCH waitrequest expected 0 seen %b", avs_waitrequest_o);
      complete_run();
    end
    @(posedge clk_sys_i);
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk_rd(a, {16'h0000, a == 8'he4 ? stat() : m[a]}, q);
  endtask

  // write, let the pins settle one edge, then compare pins and readback
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
    if (be[0]) m[a] = d[15:0] & msk(a);
    @(posedge clk_sys_i);
    chk_pins(exp_pins(), pins);
    rd_chk(a);
  endtask

  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    m[8'h78] = 16'h0060; m[8'h7c] = 16'h0020; m[8'h90] = 16'h0011; m[8'hcc] = 16'h0000;
    m[8'hd0] = 16'h0000; m[8'he0] = 16'h0000; m[8'he4] = 16'h0000; m[8'h04] = 16'h0000;
    @(posedge clk_sys_i);
    chk_pins(exp_pins(), pins);
    foreach (amap[j]) rd_chk(amap[j]);
  endtask

  // directed mode swaps, then random traffic with a reset in mid-run
  initial begin
    void'($urandom(74186));
    do_reset();
    wr_chk(8'hd0, 32'hffff_ff77, 4'hf);
    rd_chk(8'he4);
    wr_chk(8'he0, 32'h0000_0001, 4'hf);
    rd_chk(8'he4);
    wr_chk(8'hcc, 32'h0000_0018, 4'hf);
    rd_chk(8'he4);
    wr_chk(8'h7c, 32'h0000_0010, 4'hf);
    rd_chk(8'he4);
    // clock enable low stalls the handshake; the write must still land after
    ce_i <= 1'b0;
    fork
      begin
        repeat (3) @(posedge clk_sys_i);
        ce_i <= 1'b1;
      end
    join_none
    wr_chk(8'h90, 32'h0000_000a, 4'hf);
    wr_chk(8'hd0, 32'h0000_0067, 4'hf);
    wr_chk(8'hd0, 32'h0000_0000, 4'he);
    wr_chk(8'he4, 32'h0000_ffff, 4'hf);
    for (int i = 0; i < 80; i++) begin
      wr_chk(amap[$urandom_range(7)], $urandom, 4'($urandom));
      rd_chk(8'he4);
      if (i == 40) do_reset();
    end
    complete_run();
  end
endmodule
